// file: inc/periodic_keyboard_scanner_params.svh
`ifndef PERIODIC_KEYBOARD_SCANNER_PARAMS_SVH
`define PERIODIC_KEYBOARD_SCANNER_PARAMS_SVH

// ****************************************
// register byte offsets
// ****************************************
`define AUX_TIMER_CONTROL_OFFSET     8'h00
`define IRQ_ENABLE_CONTROL_OFFSET    8'h04
`define TICK_RELOAD_VALUE_OFFSET     8'h08
`define TICK_COUNT_LOW_OFFSET        8'h0C
`define TICK_COUNT_HIGH_OFFSET       8'h10
`define PROGRAM_RUNNING_FLAG_OFFSET  8'h14
`define JIFFY_COUNT_OFFSET           8'h18
`define ROW_STATE_LOW_OFFSET         8'h1C
`define ROW_STATE_HIGH_OFFSET        8'h20
`define IRQ_STATUS_OFFSET            8'h24
`define IRQ_MASK_OFFSET              8'h28

// ****************************************
// field positions and values
// ****************************************
`define CONTINUOUS_MODE_BIT          6
`define TICK_ENABLE_BIT              6
`define STATUS_TICK_BIT              0
`define STATUS_BREAK_BIT             1
`define ROW_COUNT                    8
`define LAST_ROW                     3'h7
`define COLUMN_SHIFT                 3
`define BREAK_ROW_TWO_VALUE          8'h1E
`define BREAK_ROW_THREE_VALUE        8'h0F
`define JIFFY_LOW_MAX                8'hFF
`define RESP_OKAY                    2'b00
`define RESP_SLVERR                  2'b10

// ****************************************
// reset values
// ****************************************
`define AUX_TIMER_CONTROL_RESET      8'h00
`define IRQ_ENABLE_CONTROL_RESET     8'h00
`define IRQ_MASK_RESET               2'h0

// ****************************************
// timing
// ****************************************
`define CLOCK_HZ                     10_000_000
`define TICK_RATE_HZ                 60
`define TICK_CYCLES                  (`CLOCK_HZ / `TICK_RATE_HZ)

`endif

// file: inc/scanner_pkg.sv
package scanner_pkg;

   typedef struct packed {
      logic [7:0]  awaddr;
      logic        awvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        wvalid;
      logic        bready;
      logic [7:0]  araddr;
      logic        arvalid;
      logic        rready;
   } axil_req_type;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } axil_rsp_type;

   typedef enum logic [2:0] {
      SCAN_IDLE   = 3'b000,
      SCAN_SETTLE = 3'b001,
      SCAN_SAMPLE = 3'b010,
      SCAN_COUNT  = 3'b011,
      SCAN_CHECK  = 3'b100
   } scan_state_type;

endpackage

// file: rtl/periodic_keyboard_scanner.sv
// Our own choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ns
`include "periodic_keyboard_scanner_params.svh"

// Operation
// - timer expiry gives a 60 per second tick, each starting one service cycle
// - timer reloads and repeats in continuous mode; it drives no pin
// - ticks are signalled only once the tick interrupt enable is set
// - reading the low count register clears the pending tick
// - the full matrix scan finishes before the jiffy counter advances
// - jiffy counter is two bytes; high byte steps when low byte wraps
// - break check happens only while the program running flag is nonzero
// - row two byte must equal 0x1E for a break
// - row three byte must equal 0x0F too; both needed for a break
// - thirty keys sit in six rows of five columns
// - two five-button joysticks are rows six and seven, eight rows total
// - each scan visits eight rows, overwriting one stored byte per row
// - a 3-bit row number drives the low port bits to the row switch
// - five column bits from upper port bits are stored shifted right by three
// - scan starts at row zero and steps by one after each stored row
// - column bits are active low; one means released
module periodic_keyboard_scanner
#(
   parameter logic [31:0] TICK_CYCLES = `TICK_CYCLES
)
(
   input  wire logic                      aclk,
   input  wire logic                      aresetn,
   input  wire scanner_pkg::axil_req_type axil_req,
   output      scanner_pkg::axil_rsp_type axil_rsp,
   input  wire logic [7:0]                row_select_column_port_in,
   output      logic [2:0]                row_select_column_port_out,
   output      logic                      irq,
   output      logic                      break_request
);
   import scanner_pkg::*;

   // ****************************************
   // register bus state
   // ****************************************
   logic                          aw_held;
   logic [7:0]                    aw_addr;
   logic                          w_held;
   logic [31:0]                   w_data;
   logic [3:0]                    w_strb;
   logic                          bvalid;
   logic [1:0]                    bresp;
   logic                          rvalid;
   logic [31:0]                   rdata;
   logic [1:0]                    rresp;
   logic                          do_write;
   logic                          read_take;
   logic [31:0]                   next_rdata;
   logic                          next_rhit;

   // ****************************************
   // software visible registers and block state
   // ****************************************
   logic [7:0]                    aux_timer_control;
   logic [7:0]                    irq_enable_control;
   logic [31:0]                   tick_reload_value;
   logic [31:0]                   tick_count;
   logic                          timer_run;
   logic [7:0]                    program_running_flag;
   logic [7:0]                    jiffy_low;
   logic [7:0]                    jiffy_high;
   logic [7:0]                    row_state_bytes [`ROW_COUNT];
   logic [1:0]                    irq_status;
   logic [1:0]                    irq_mask;
   scan_state_type                matrix_scan_step;
   logic                          tick_expire;
   logic                          tick_fire;
   logic                          break_hit;
   logic                          low_count_read;
   logic [7:0]                    row_two_state;
   logic [7:0]                    row_three_state;

   function automatic logic [31:0] merge_bytes(input logic [31:0] old_value,
                                               input logic [31:0] new_value,
                                               input logic [3:0]  strobes);
      logic [31:0] merged;
      merged = old_value;
      for (int i = 0; i < 4; i++)
         if (strobes[i])
            merged[i*8 +: 8] = new_value[i*8 +: 8];
      return merged;
   endfunction

   // ****************************************
   // AXI4-Lite slave
   // ****************************************
   assign do_write  = aw_held && w_held && !bvalid;
   assign read_take = axil_req.arvalid && !rvalid;

   // address and data may come in either order; one write at a time
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held <= 1'b0;
         aw_addr <= 8'h00;
         w_held  <= 1'b0;
         w_data  <= 32'h0000_0000;
         w_strb  <= 4'h0;
         bvalid  <= 1'b0;
         bresp   <= `RESP_OKAY;
      end
      else
      begin
         if (axil_req.awvalid && !aw_held && !bvalid)
         begin
            aw_held <= 1'b1;
            aw_addr <= axil_req.awaddr;
         end
         if (axil_req.wvalid && !w_held && !bvalid)
         begin
            w_held <= 1'b1;
            w_data <= axil_req.wdata;
            w_strb <= axil_req.wstrb;
         end
         if (do_write)
         begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            bvalid  <= 1'b1;
            bresp   <= (aw_addr == `AUX_TIMER_CONTROL_OFFSET
                     || aw_addr == `IRQ_ENABLE_CONTROL_OFFSET
                     || aw_addr == `TICK_RELOAD_VALUE_OFFSET
                     || aw_addr == `PROGRAM_RUNNING_FLAG_OFFSET
                     || aw_addr == `IRQ_STATUS_OFFSET
                     || aw_addr == `IRQ_MASK_OFFSET) ? `RESP_OKAY : `RESP_SLVERR;
         end
         else if (bvalid && axil_req.bready)
            bvalid <= 1'b0;
      end
   end

   always_comb
   begin
      next_rdata = 32'h0000_0000;
      next_rhit  = 1'b1;
      if (axil_req.araddr == `AUX_TIMER_CONTROL_OFFSET)
         next_rdata = {24'h00_0000, aux_timer_control};
      else if (axil_req.araddr == `IRQ_ENABLE_CONTROL_OFFSET)
         next_rdata = {24'h00_0000, irq_enable_control};
      else if (axil_req.araddr == `TICK_RELOAD_VALUE_OFFSET)
         next_rdata = tick_reload_value;
      else if (axil_req.araddr == `TICK_COUNT_LOW_OFFSET)
         next_rdata = {16'h0000, tick_count[15:0]};
      else if (axil_req.araddr == `TICK_COUNT_HIGH_OFFSET)
         next_rdata = {16'h0000, tick_count[31:16]};
      else if (axil_req.araddr == `PROGRAM_RUNNING_FLAG_OFFSET)
         next_rdata = {24'h00_0000, program_running_flag};
      else if (axil_req.araddr == `JIFFY_COUNT_OFFSET)
         next_rdata = {16'h0000, jiffy_high, jiffy_low};
      else if (axil_req.araddr == `ROW_STATE_LOW_OFFSET)
         next_rdata = {row_state_bytes[3], row_state_bytes[2],
                       row_state_bytes[1], row_state_bytes[0]};
      else if (axil_req.araddr == `ROW_STATE_HIGH_OFFSET)
         next_rdata = {row_state_bytes[7], row_state_bytes[6],
                       row_state_bytes[5], row_state_bytes[4]};
      else if (axil_req.araddr == `IRQ_STATUS_OFFSET)
         next_rdata = {30'h0000_0000, irq_status};
      else if (axil_req.araddr == `IRQ_MASK_OFFSET)
         next_rdata = {30'h0000_0000, irq_mask};
      else
         next_rhit = 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid <= 1'b0;
         rdata  <= 32'h0000_0000;
         rresp  <= `RESP_OKAY;
      end
      else if (read_take)
      begin
         rvalid <= 1'b1;
         rdata  <= next_rdata;
         rresp  <= next_rhit ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (rvalid && axil_req.rready)
         rvalid <= 1'b0;
   end

   assign low_count_read = read_take && axil_req.araddr == `TICK_COUNT_LOW_OFFSET;

   always_comb
   begin
      axil_rsp         = '0;
      axil_rsp.awready = !aw_held && !bvalid;
      axil_rsp.wready  = !w_held && !bvalid;
      axil_rsp.bvalid  = bvalid;
      axil_rsp.bresp   = bresp;
      axil_rsp.arready = !rvalid;
      axil_rsp.rvalid  = rvalid;
      axil_rsp.rdata   = rdata;
      axil_rsp.rresp   = rresp;
   end

   // ****************************************
   // control registers
   // ****************************************
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aux_timer_control    <= `AUX_TIMER_CONTROL_RESET;
         irq_enable_control   <= `IRQ_ENABLE_CONTROL_RESET;
         tick_reload_value    <= TICK_CYCLES - 32'h0000_0001;
         program_running_flag <= 8'h00;
         irq_mask             <= `IRQ_MASK_RESET;
      end
      else if (do_write)
      begin
         if (aw_addr == `AUX_TIMER_CONTROL_OFFSET)
            aux_timer_control <= 8'(merge_bytes({24'h00_0000, aux_timer_control},
                                                w_data, w_strb));
         else if (aw_addr == `IRQ_ENABLE_CONTROL_OFFSET)
            irq_enable_control <= 8'(merge_bytes({24'h00_0000, irq_enable_control},
                                                 w_data, w_strb));
         else if (aw_addr == `TICK_RELOAD_VALUE_OFFSET)
            tick_reload_value <= merge_bytes(tick_reload_value, w_data, w_strb);
         else if (aw_addr == `PROGRAM_RUNNING_FLAG_OFFSET)
            program_running_flag <= 8'(merge_bytes({24'h00_0000, program_running_flag},
                                                   w_data, w_strb));
         else if (aw_addr == `IRQ_MASK_OFFSET && w_strb[0])
            irq_mask <= w_data[1:0];
      end
   end

   // ****************************************
   // tick timer
   // ****************************************
   assign tick_expire = timer_run && tick_count == 32'h0000_0000;
   assign tick_fire   = tick_expire && irq_enable_control[`TICK_ENABLE_BIT];

   // no pin output: expiry feeds the service cycle and the tick status bit
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         tick_count <= TICK_CYCLES - 32'h0000_0001;
         timer_run  <= 1'b1;
      end
      else if (do_write && aw_addr == `TICK_RELOAD_VALUE_OFFSET)
      begin
         // a new reload value restarts the period, also from one-shot stop
         tick_count <= merge_bytes(tick_reload_value, w_data, w_strb);
         timer_run  <= 1'b1;
      end
      else if (tick_expire)
      begin
         tick_count <= tick_reload_value;
         timer_run  <= aux_timer_control[`CONTINUOUS_MODE_BIT];
      end
      else if (timer_run)
         tick_count <= tick_count - 32'h0000_0001;
   end

   // ****************************************
   // service cycle: scan, count, break check
   // ****************************************
   assign row_two_state   = row_state_bytes[2];
   assign row_three_state = row_state_bytes[3];
   assign break_hit       = program_running_flag != 8'h00
                         && row_two_state == `BREAK_ROW_TWO_VALUE
                         && row_three_state == `BREAK_ROW_THREE_VALUE;

   // a tick landing mid service is dropped; a service is 18 clocks
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         matrix_scan_step           <= SCAN_IDLE;
         row_select_column_port_out <= 3'h0;
         break_request              <= 1'b0;
      end
      else
      begin
         break_request <= 1'b0;
         case (matrix_scan_step)
            SCAN_IDLE:
               if (tick_fire)
               begin
                  row_select_column_port_out <= 3'h0;
                  matrix_scan_step           <= SCAN_SETTLE;
               end
            SCAN_SETTLE:
               matrix_scan_step <= SCAN_SAMPLE;
            SCAN_SAMPLE:
               if (row_select_column_port_out == `LAST_ROW)
                  matrix_scan_step <= SCAN_COUNT;
               else
               begin
                  row_select_column_port_out <= 3'(row_select_column_port_out + 3'h1);
                  matrix_scan_step           <= SCAN_SETTLE;
               end
            SCAN_COUNT:
               matrix_scan_step <= SCAN_CHECK;
            SCAN_CHECK:
            begin
               break_request    <= break_hit;
               matrix_scan_step <= SCAN_IDLE;
            end
            default:
               matrix_scan_step <= SCAN_IDLE;
         endcase
      end
   end

   // rows 0..5 keyboard, 6..7 joysticks; bits kept raw, low means pressed
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         for (int i = 0; i < `ROW_COUNT; i++)
            row_state_bytes[i] <= 8'hFF >> `COLUMN_SHIFT;
      end
      else if (matrix_scan_step == SCAN_SAMPLE)
      begin
         row_state_bytes[row_select_column_port_out] <=
            row_select_column_port_in >> `COLUMN_SHIFT;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         jiffy_low  <= 8'h00;
         jiffy_high <= 8'h00;
      end
      else if (matrix_scan_step == SCAN_COUNT)
      begin
         jiffy_low <= 8'(jiffy_low + 8'h01);
         if (jiffy_low == `JIFFY_LOW_MAX)
            jiffy_high <= 8'(jiffy_high + 8'h01);
      end
   end

   // ****************************************
   // interrupt status, set wins over clear
   // ****************************************
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         irq_status <= 2'h0;
      else
      begin
         for (int i = 0; i < 2; i++)
            if (do_write && aw_addr == `IRQ_STATUS_OFFSET && w_strb[0] && w_data[i])
               irq_status[i] <= 1'b0;
         if (low_count_read)
            irq_status[`STATUS_TICK_BIT] <= 1'b0;
         if (tick_fire)
            irq_status[`STATUS_TICK_BIT] <= 1'b1;
         if (matrix_scan_step == SCAN_CHECK && break_hit)
            irq_status[`STATUS_BREAK_BIT] <= 1'b1;
      end
   end

   assign irq = |(irq_status & irq_mask);

endmodule

// file: verif/periodic_keyboard_scanner_chk.sv
`timescale 1ns/1ns
// ********************
// port checks
// ********************
module periodic_keyboard_scanner_chk
(
   input wire logic                      aclk,
   input wire logic                      aresetn,
   input wire scanner_pkg::axil_req_type axil_req,
   input wire scanner_pkg::axil_rsp_type axil_rsp,
   input wire logic [7:0]                row_select_column_port_in,
   input wire logic [2:0]                row_select_column_port_out,
   input wire logic                      irq,
   input wire logic                      break_request
);
   import scanner_pkg::*;
   logic [2:0] row;
   assign row = row_select_column_port_out;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_break_pulse;
      break_request |=> !break_request;
   endproperty
   a_break_pulse: assert property (p_break_pulse)
      else $error("break pulse too long");

   property p_break_timing;
      break_request |-> $past(row, 4) == 3'h7 && $past(row, 5) == 3'h6;
   endproperty
   a_break_timing: assert property (p_break_timing)
      else $error("break check not after full scan");

   property p_row_step;
      $changed(row) |-> row == $past(row) + 3'h1 || row == 3'h0;
   endproperty
   a_row_step: assert property (p_row_step)
      else $error("row select skipped");

   property p_row_hold;
      $changed(row) |=> $stable(row);
   endproperty
   a_row_hold: assert property (p_row_hold)
      else $error("row select not held");

   property p_scan_order;
      row == 3'h1 && $past(row) == 3'h0 |-> ##2 row == 3'h2 ##2 row == 3'h3 ##2 row == 3'h4
         ##2 row == 3'h5 ##2 row == 3'h6 ##2 row == 3'h7;
   endproperty
   a_scan_order: assert property (p_scan_order)
      else $error("scan order broken");

   property p_read_answer;
      axil_req.arvalid && axil_rsp.arready |=> axil_rsp.rvalid;
   endproperty
   a_read_answer: assert property (p_read_answer)
      else $error("read answer late");

   property p_write_answer;
      axil_req.awvalid && axil_rsp.awready && axil_req.wvalid && axil_rsp.wready
         |=> !axil_rsp.bvalid ##1 axil_rsp.bvalid;
   endproperty
   a_write_answer: assert property (p_write_answer)
      else $error("write answer timing");

   property p_read_release;
      axil_rsp.rvalid && axil_req.rready |=> !axil_rsp.rvalid;
   endproperty
   a_read_release: assert property (p_read_release)
      else $error("read answer stuck");

   property p_ar_refuse;
      axil_rsp.arready == !axil_rsp.rvalid;
   endproperty
   a_ar_refuse: assert property (p_ar_refuse)
      else $error("read address ready wrong");
endmodule

// file: verif/key_matrix_model.sv
`timescale 1ns/1ns
// ********************
// key and joystick matrix
// ********************
module key_matrix_model
(
   input  wire logic [2:0]  row_sel,
   input  wire logic [39:0] keys,
   output      logic [7:0]  port_in
);
   // rows 0-5 keyboard, 6-7 joysticks; low bits unused, kept moving
   assign port_in = {keys[5 * row_sel +: 5], ~row_sel};
endmodule

// file: verif/periodic_keyboard_scanner_tb.sv
`timescale 1ns/1ns
`include "periodic_keyboard_scanner_params.svh"
// ********************
// bench
// ********************
module periodic_keyboard_scanner_tb;
   import scanner_pkg::*;
   localparam int TICK = 60;
   logic         aclk = 1'b0;
   logic         aresetn;
   axil_req_type req;
   axil_rsp_type rsp;
   logic [7:0]   port_in;
   logic [2:0]   port_out;
   logic         irq;
   logic         break_request;
   logic [39:0]  keys;
   logic [39:0]  k;
   logic [31:0]  q;
   logic [1:0]   r;
   logic [7:0]   fv;
   logic         be;
   int           fails = 0;
   int           checked = 0;
   int           cyc = 0;
   int           pulses = 0;
   int           seed;
   int           it;
   int           t;
   int           tp;
   int           jexp;
   int           pexp;

   periodic_keyboard_scanner #(.TICK_CYCLES(TICK)) dut
   (
      .aclk                       (aclk),
      .aresetn                    (aresetn),
      .axil_req                   (req),
      .axil_rsp                   (rsp),
      .row_select_column_port_in  (port_in),
      .row_select_column_port_out (port_out),
      .irq                        (irq),
      .break_request              (break_request)
   );
   key_matrix_model u_matrix (.row_sel(port_out), .keys(keys), .port_in(port_in));

   always #50 aclk = ~aclk;
   always @(posedge aclk)
   begin
      cyc <= cyc + 1;
      if (break_request === 1'b1)
         pulses <= pulses + 1;
   end

   task automatic final_report();
      $display("checked=%0d fails=%0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         fails++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic give_up(input int n, input int lim);
      if (n >= lim)
      begin
         fails++;
         final_report();
      end
   endtask

   // one transfer; waits decided at the falling edge, so the rising edge sees them settled
   task automatic bus(input bit wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic [1:0] r);
      int   n;
      logic ha;
      logic hw;
      logic hr;
      @(posedge aclk);
      req.awaddr  <= a;
      req.araddr  <= a;
      req.wdata   <= d;
      req.wstrb   <= 4'hF;
      req.awvalid <= wr;
      req.wvalid  <= wr;
      req.bready  <= wr;
      req.arvalid <= !wr;
      req.rready  <= !wr;
      for (n = 0; n < 64; n++)
      begin
         @(negedge aclk);
         ha = req.awvalid && rsp.awready || req.arvalid && rsp.arready;
         hw = req.wvalid && rsp.wready;
         hr = req.bready && rsp.bvalid || req.rready && rsp.rvalid;
         q = rsp.rdata;
         r = wr ? rsp.bresp : rsp.rresp;
         @(posedge aclk);
         if (ha)
            {req.awvalid, req.arvalid} <= 2'b00;
         if (hw)
            req.wvalid <= 1'b0;
         if (hr)
            break;
      end
      {req.bready, req.rready} <= 2'b00;
      give_up(n, 64);
   endtask

   task automatic wait_irq(output int tt);
      int n;
      for (n = 0; n < 200; n++)
      begin
         @(negedge aclk);
         if (irq === 1'b1)
            break;
      end
      @(posedge aclk);
      tt = cyc;
      give_up(n, 200);
   endtask

   function automatic logic [31:0] row_word(input logic [19:0] s);
      return {3'h0, s[19:15], 3'h0, s[14:10], 3'h0, s[9:5], 3'h0, s[4:0]};
   endfunction

   initial
   begin
      seed = 32'h558a;
      req = '0;
      keys = '1;
      aresetn = 1'b0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (TICK + 20) @(posedge aclk);
      bus(0, `IRQ_STATUS_OFFSET, 32'h0, q, r);
      check(q, 32'h0);
      bus(0, `JIFFY_COUNT_OFFSET, 32'h0, q, r);
      check(q, 32'h0);
      bus(0, `ROW_STATE_HIGH_OFFSET, 32'h0, q, r);
      check(q, 32'h1F1F_1F1F);
      // one-shot default: after its single expiry the count rests at the reload value
      bus(0, `TICK_COUNT_LOW_OFFSET, 32'h0, q, r);
      check(q, TICK - 1);
      bus(0, 8'h30, 32'h0, q, r);
      check(q, 32'h0);
      check(r, `RESP_SLVERR);
      bus(1, `TICK_COUNT_LOW_OFFSET, 32'h0, q, r);
      check(r, `RESP_SLVERR);
      bus(1, `AUX_TIMER_CONTROL_OFFSET, 32'h40, q, r);
      bus(1, `IRQ_ENABLE_CONTROL_OFFSET, 32'h40, q, r);
      bus(1, `IRQ_MASK_OFFSET, 32'h3, q, r);
      bus(1, `TICK_RELOAD_VALUE_OFFSET, TICK - 1, q, r);
      jexp = 0;
      pexp = 0;
      // first four ticks walk the break table, the rest run past the low byte wrap
      for (it = 0; it < 262; it++)
      begin
         k = 40'({$random(seed), $random(seed)});
         fv = 8'($random(seed)) & 8'h03;
         if (it < 4)
         begin
            fv = (it == 0) ? 8'h00 : 8'h80;
            k[14:10] = (it == 2) ? 5'h1F : 5'h1E;
            k[19:15] = (it == 3) ? 5'h0E : 5'h0F;
         end
         @(posedge aclk);
         keys <= k;
         bus(1, `PROGRAM_RUNNING_FLAG_OFFSET, {24'h0, fv}, q, r);
         wait_irq(t);
         if (it > 0)
            check(t - tp, TICK);
         tp = t;
         bus(0, `TICK_COUNT_LOW_OFFSET, 32'h0, q, r);
         bus(0, `JIFFY_COUNT_OFFSET, 32'h0, q, r);
         check(q, jexp);
         repeat (22) @(posedge aclk);
         jexp++;
         be = fv != 8'h00 && k[14:10] == 5'h1E && k[19:15] == 5'h0F;
         pexp += be;
         check(pulses, pexp);
         bus(0, `IRQ_STATUS_OFFSET, 32'h0, q, r);
         check(q, {30'h0, be, 1'b0});
         bus(0, `ROW_STATE_LOW_OFFSET, 32'h0, q, r);
         check(q, row_word(k[19:0]));
         bus(0, `ROW_STATE_HIGH_OFFSET, 32'h0, q, r);
         check(q, row_word(k[39:20]));
         bus(0, `JIFFY_COUNT_OFFSET, 32'h0, q, r);
         check(q, jexp);
         bus(1, `IRQ_STATUS_OFFSET, 32'h3, q, r);
         @(negedge aclk);
         check(irq, 1'b0);
      end
      bus(1, `IRQ_MASK_OFFSET, 32'h0, q, r);
      repeat (TICK + 10) @(posedge aclk);
      @(negedge aclk);
      check(irq, 1'b0);
      bus(0, `IRQ_STATUS_OFFSET, 32'h0, q, r);
      check(q[0], 1'b1);
      bus(1, `IRQ_MASK_OFFSET, 32'h1, q, r);
      @(negedge aclk);
      check(irq, 1'b1);
      final_report();
   end
endmodule

bind periodic_keyboard_scanner periodic_keyboard_scanner_chk u_chk
(
   .aclk                       (aclk),
   .aresetn                    (aresetn),
   .axil_req                   (axil_req),
   .axil_rsp                   (axil_rsp),
   .row_select_column_port_in  (row_select_column_port_in),
   .row_select_column_port_out (row_select_column_port_out),
   .irq                        (irq),
   .break_request              (break_request)
);
